// ---- hw/pwm_fan_drive_control.sv ----
/*
  Three-channel fan drive: register file, spin-up control, start-up timeout
  fault flags, waveform generators and the xor test chain enable.
  Assumes the serial management interface presents decoded single-byte
  register reads and writes on this clock, and that the automatic control
  loop supplies its duty per channel on this clock.
*/
`timescale 1ns/10ps

module pwm_fan_drive_control #(
  parameter int unsigned SPIN_CYCLES [8] = pwm_fan_pkg::SPIN_CYC,
  parameter int unsigned RATE_DIVIDERS [8] = pwm_fan_pkg::RATE_DIV
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [2:0][7:0] auto_duty_i,
  input wire logic [2:0] tach_i,
  input wire logic [2:0] xor_chain_pins_i,
  output logic [2:0] pwm_o,
  output logic [2:0] fan_fault_o,
  output logic xor_chain_enable_o,
  output logic xor_chain_result_o
);

  localparam int unsigned NCH = pwm_fan_pkg::NUM_CH;
  localparam int unsigned TW = pwm_fan_pkg::TIMER_W;

  typedef struct packed {
    logic [7:0] gcfg;
    logic [7:0] xor_test;
    logic [2:0][7:0] chcfg;
    logic [2:0][2:0] rate;
    logic [2:0][7:0] duty;
    logic [2:0] fault;
    logic [2:0][1:0] tsync;
    logic [2:0] tprev;
    logic [2:0][1:0] pulses;
    pwm_fan_pkg::spin_state_e [2:0] st;
    logic [2:0][TW-1:0] timer;
    logic [2:0][7:0] applied;
    logic [1:0][2:0] xsync;
    logic xor_out;
    logic [7:0] rdata;
  } state_s;

  state_s q_r, q_nxt;

  logic fixed_spin;
  logic [2:0] manual;
  logic [2:0][7:0] target;
  logic [2:0][2:0] spin_sel;
  logic [2:0][TW-1:0] spin_last;
  logic [2:0] tach_rise;
  logic [2:0] spin_timed_out;
  logic [2:0] fault_clr;
  logic [7:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // per-channel decode of the register fields
  always_comb begin
    fixed_spin = q_r.gcfg[pwm_fan_pkg::FIXED_SPINUP_BIT];
    for (int i = 0; i < NCH; i++) begin
      manual[i] = q_r.chcfg[i][pwm_fan_pkg::BEHAV_LSB +: 3] == pwm_fan_pkg::BEHAV_MANUAL;
      target[i] = manual[i] ? q_r.duty[i] : auto_duty_i[i];
      spin_sel[i] = q_r.chcfg[i][2:0];
      spin_last[i] = TW'(SPIN_CYCLES[spin_sel[i]] - 1);
      tach_rise[i] = q_r.tsync[i][1] && !q_r.tprev[i];
      spin_timed_out[i] = (spin_sel[i] != pwm_fan_pkg::SPIN_NONE) && (q_r.timer[i] >= spin_last[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    fault_clr = 3'h0;
    if (reg_addr_i >= pwm_fan_pkg::OFS_DUTY_1 && reg_addr_i <= pwm_fan_pkg::OFS_DUTY_3) begin
      rd_mux = q_r.applied[2'(reg_addr_i - pwm_fan_pkg::OFS_DUTY_1)];
    end else if (reg_addr_i >= pwm_fan_pkg::OFS_CHCFG_1 && reg_addr_i <= pwm_fan_pkg::OFS_CHCFG_3) begin
      rd_mux = q_r.chcfg[2'(reg_addr_i - pwm_fan_pkg::OFS_CHCFG_1)];
    end else if (reg_addr_i >= pwm_fan_pkg::OFS_RATE_1 && reg_addr_i <= pwm_fan_pkg::OFS_RATE_3) begin
      rd_mux = {5'h00, q_r.rate[2'(reg_addr_i - pwm_fan_pkg::OFS_RATE_1)]};
    end else if (reg_addr_i == pwm_fan_pkg::OFS_GCFG_1) begin
      rd_mux = q_r.gcfg;
    end else if (reg_addr_i == pwm_fan_pkg::OFS_XOR_TEST) begin
      rd_mux = q_r.xor_test;
    end else if (reg_addr_i == pwm_fan_pkg::OFS_FAULT_STATUS) begin
      rd_mux = {3'h0, q_r.fault, 2'h0};
      // a read is what clears the sticky fan faults
      fault_clr = reg_rd_i ? 3'h7 : 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.rdata = reg_rd_i ? rd_mux : q_r.rdata;

    if (reg_wr_i) begin
      if (reg_addr_i >= pwm_fan_pkg::OFS_CHCFG_1 && reg_addr_i <= pwm_fan_pkg::OFS_CHCFG_3) begin
        q_nxt.chcfg[2'(reg_addr_i - pwm_fan_pkg::OFS_CHCFG_1)] = reg_wdata_i;
      end else if (reg_addr_i >= pwm_fan_pkg::OFS_RATE_1 && reg_addr_i <= pwm_fan_pkg::OFS_RATE_3) begin
        q_nxt.rate[2'(reg_addr_i - pwm_fan_pkg::OFS_RATE_1)] = reg_wdata_i[2:0];
      end else if (reg_addr_i == pwm_fan_pkg::OFS_GCFG_1) begin
        q_nxt.gcfg = reg_wdata_i;
      end else if (reg_addr_i == pwm_fan_pkg::OFS_XOR_TEST) begin
        q_nxt.xor_test = {7'h00, reg_wdata_i[pwm_fan_pkg::XOR_ENABLE_BIT]};
      end
    end

    // board test chain: synchronised pins folded into one parity bit
    q_nxt.xsync[0] = xor_chain_pins_i;
    q_nxt.xsync[1] = q_r.xsync[0];
    q_nxt.xor_out = q_r.xor_test[pwm_fan_pkg::XOR_ENABLE_BIT] && (^q_r.xsync[1]);

    for (int i = 0; i < NCH; i++) begin
      // duty writes only land in manual mode; otherwise the loop owns it
      if (manual[i]) begin
        if (reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1 + 8'(i)) begin
          q_nxt.duty[i] = reg_wdata_i;
        end
      end else begin
        q_nxt.duty[i] = auto_duty_i[i];
      end

      q_nxt.tsync[i] = {q_r.tsync[i][0], tach_i[i]};
      q_nxt.tprev[i] = q_r.tsync[i][1];

      q_nxt.fault[i] = q_r.fault[i] && !fault_clr[i];

      unique case (q_r.st[i])
        pwm_fan_pkg::SPIN_OFF: begin
          q_nxt.applied[i] = pwm_fan_pkg::DUTY_ZERO;
          q_nxt.timer[i] = '0;
          q_nxt.pulses[i] = 2'h0;
          if (target[i] != pwm_fan_pkg::DUTY_ZERO) begin
            q_nxt.st[i] = pwm_fan_pkg::SPIN_UP;
            q_nxt.applied[i] = pwm_fan_pkg::DUTY_FULL;
          end
        end
        pwm_fan_pkg::SPIN_UP: begin
          q_nxt.applied[i] = pwm_fan_pkg::DUTY_FULL;
          q_nxt.timer[i] = q_r.timer[i] + TW'(1);
          if (tach_rise[i] && q_r.pulses[i] != pwm_fan_pkg::PULSES_DONE) begin
            q_nxt.pulses[i] = q_r.pulses[i] + 2'h1;
          end
          if (fixed_spin) begin
            // fixed time: tach ignored, no fault, code none ends spin-up after one cycle at full duty
            if (spin_sel[i] == pwm_fan_pkg::SPIN_NONE || spin_timed_out[i]) begin
              q_nxt.st[i] = pwm_fan_pkg::SPIN_RUN;
              q_nxt.applied[i] = target[i];
            end
          end else if (q_nxt.pulses[i] == pwm_fan_pkg::PULSES_DONE) begin
            q_nxt.st[i] = pwm_fan_pkg::SPIN_RUN;
            q_nxt.applied[i] = target[i];
          end else if (spin_timed_out[i]) begin
            // give up waiting, raise the fault and hand over to the target duty
            q_nxt.fault[i] = 1'b1;
            q_nxt.st[i] = pwm_fan_pkg::SPIN_RUN;
            q_nxt.applied[i] = target[i];
          end
        end
        pwm_fan_pkg::SPIN_RUN: begin
          q_nxt.applied[i] = target[i];
          if (target[i] == pwm_fan_pkg::DUTY_ZERO) begin
            q_nxt.st[i] = pwm_fan_pkg::SPIN_OFF;
          end
        end
        default: begin
          q_nxt.st[i] = pwm_fan_pkg::SPIN_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q_r <= '0;
      q_r.gcfg <= pwm_fan_pkg::GCFG_RST;
      q_r.chcfg <= {NCH{pwm_fan_pkg::CHCFG_RST}};
      q_r.rate <= {NCH{pwm_fan_pkg::RATE_RST}};
      q_r.duty <= {NCH{pwm_fan_pkg::DUTY_RST}};
      q_r.st <= '{default: pwm_fan_pkg::SPIN_OFF};
    end else begin
      q_r <= q_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // waveform per channel
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      pwm_wave_gen u_wave (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .div_i(pwm_fan_pkg::DIV_W'(RATE_DIVIDERS[q_r.rate[g]])),
        .duty_i(q_r.applied[g]),
        .invert_i(q_r.chcfg[g][pwm_fan_pkg::POLARITY_BIT]),
        .pwm_o(pwm_o[g])
      );
    end
  endgenerate

  assign reg_rdata_o = q_r.rdata;
  assign fan_fault_o = q_r.fault;
  assign xor_chain_enable_o = q_r.xor_test[pwm_fan_pkg::XOR_ENABLE_BIT];
  assign xor_chain_result_o = q_r.xor_out;

  //////////////////////////////////////////////////////////////////////////////
  // checks, channel 0 stands for all three
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_spinning;
    q_r.st[0] == pwm_fan_pkg::SPIN_UP;
  endsequence

  sequence s_manual_write;
    manual[0] && reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1;
  endsequence

  a_spin_full_duty: assert property (s_spinning |=> q_r.applied[0] == pwm_fan_pkg::DUTY_FULL
    || q_r.st[0] == pwm_fan_pkg::SPIN_RUN)
    else $error("spin-up not at full duty");

  a_fault_from_timeout: assert property ($rose(q_r.fault[0]) |-> $past(q_r.st[0]) == pwm_fan_pkg::SPIN_UP
    && !$past(fixed_spin) && $past(q_r.pulses[0]) != pwm_fan_pkg::PULSES_DONE)
    else $error("fan fault without a spin-up timeout");

  a_fault_sticky: assert property (q_r.fault[0] && !fault_clr[0] |=> q_r.fault[0])
    else $error("fan fault dropped without a status read");

  a_fixed_ignores_tach: assert property (s_spinning and fixed_spin && !spin_timed_out[0]
    && spin_sel[0] != pwm_fan_pkg::SPIN_NONE && !reg_wr_i |=> s_spinning)
    else $error("fixed spin-up ended early");

  a_fixed_no_fault: assert property (s_spinning and fixed_spin && spin_timed_out[0]
    |=> q_r.st[0] == pwm_fan_pkg::SPIN_RUN && !$rose(q_r.fault[0]))
    else $error("fixed spin-up did not end at its time");

  a_two_pulses_end: assert property (s_spinning and !fixed_spin && q_nxt.pulses[0] == pwm_fan_pkg::PULSES_DONE
    |=> q_r.st[0] == pwm_fan_pkg::SPIN_RUN ##1 q_r.applied[0] == $past(target[0]) || q_r.st[0] != pwm_fan_pkg::SPIN_RUN)
    else $error("spin-up did not end after two pulses");

  a_manual_duty_write: assert property (s_manual_write ##0 (q_r.st[0] == pwm_fan_pkg::SPIN_RUN)
    ##1 (manual[0] && q_r.st[0] == pwm_fan_pkg::SPIN_RUN && !reg_wr_i) |=> q_r.applied[0] == $past(reg_wdata_i, 2))
    else $error("manual duty not applied");

  a_read_applied: assert property (reg_rd_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1
    |=> reg_rdata_o == $past(q_r.applied[0]))
    else $error("duty read is not the applied duty");

  a_duty_reset_full: assert property ($rose(rstn_i) |-> q_r.duty == {NCH{pwm_fan_pkg::DUTY_RST}}
    && q_r.chcfg[0][2:0] == pwm_fan_pkg::CHCFG_RST[2:0])
    else $error("reset values wrong");

  a_xor_enable: assert property (!xor_chain_enable_o [*2] |-> !xor_chain_result_o)
    else $error("xor result active while test mode is off");

  a_xor_enable_write: assert property (reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_XOR_TEST
    |=> xor_chain_enable_o == $past(reg_wdata_i[pwm_fan_pkg::XOR_ENABLE_BIT]))
    else $error("xor test enable not stored");

  //////////////////////////////////////////////////////////////////////////////
  // checks per channel; catches a crossed channel index that channel 0 alone would miss
  // clock named in each, so the generate scope leans on no default
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_chk
      a_idle_zero_duty: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        q_r.st[c] == pwm_fan_pkg::SPIN_OFF && target[c] == pwm_fan_pkg::DUTY_ZERO
        |=> q_r.applied[c] == pwm_fan_pkg::DUTY_ZERO)
        else $error("idle channel not at zero duty");

      a_start_at_full: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        q_r.st[c] == pwm_fan_pkg::SPIN_OFF && target[c] != pwm_fan_pkg::DUTY_ZERO
        |=> q_r.st[c] == pwm_fan_pkg::SPIN_UP && q_r.applied[c] == pwm_fan_pkg::DUTY_FULL)
        else $error("spin-up did not start at full duty");

      a_spin_ends_run: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        q_r.st[c] == pwm_fan_pkg::SPIN_UP && q_nxt.st[c] == pwm_fan_pkg::SPIN_RUN
        |=> q_r.applied[c] == $past(target[c]))
        else $error("spin-up did not hand over to the running duty");

      a_run_stops_at_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        q_r.st[c] == pwm_fan_pkg::SPIN_RUN && target[c] == pwm_fan_pkg::DUTY_ZERO
        |=> q_r.st[c] == pwm_fan_pkg::SPIN_OFF && q_r.applied[c] == pwm_fan_pkg::DUTY_ZERO)
        else $error("zero duty did not stop the channel");

      a_auto_follows_loop: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        q_r.st[c] == pwm_fan_pkg::SPIN_RUN && !manual[c] |=> q_r.applied[c] == $past(auto_duty_i[c]))
        else $error("automatic duty not applied");

      a_duty_write_refused: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !manual[c] && reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1 + 8'(c)
        |=> q_r.duty[c] == $past(auto_duty_i[c]))
        else $error("duty write landed outside manual mode");

      a_manual_duty_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        manual[c] && !(reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1 + 8'(c)) |=> $stable(q_r.duty[c]))
        else $error("manual duty changed without a write");

      a_read_duty_applied: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == pwm_fan_pkg::OFS_DUTY_1 + 8'(c) |=> reg_rdata_o == $past(q_r.applied[c]))
        else $error("duty read differs from the applied duty");

      a_fault_needs_spin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(q_r.fault[c]) |-> $past(q_r.st[c]) == pwm_fan_pkg::SPIN_UP && !$past(fixed_spin))
        else $error("fan fault outside a tach-ended spin-up");

      a_status_bit_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == pwm_fan_pkg::OFS_FAULT_STATUS
        |=> reg_rdata_o[pwm_fan_pkg::FAULT_LSB + c] == $past(q_r.fault[c]))
        else $error("fault status bit does not show the flag");

      a_config_stored: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_CHCFG_1 + 8'(c) |=> q_r.chcfg[c] == $past(reg_wdata_i))
        else $error("channel config not stored");

      a_rate_code_stored: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == pwm_fan_pkg::OFS_RATE_1 + 8'(c) |=> q_r.rate[c] == $past(reg_wdata_i[2:0]))
        else $error("rate code not stored");
    end
  endgenerate

endmodule // pwm_fan_drive_control

// ---- hw/pwm_fan_pkg.sv ----
/*
  Shared constants for the three-channel fan drive block: register offsets,
  field positions, reset values, code tables and clock-derived counts.
  Assumes a single 250 MHz core clock.
*/
package pwm_fan_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and derived rates
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // one period is 256 counter steps; rate table is in hundredths of a hertz
  localparam int unsigned STEP_HZ_X100 = (CLK_HZ / 256) * 100;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned TIMER_W = 30;
  localparam int unsigned DIV_W = 17;

  //////////////////////////////////////////////////////////////////////////////
  // start-up timeout table, milliseconds, index = timeout code
  localparam int unsigned SPIN_MS [8] = '{0, 100, 250, 400, 667, 1000, 2000, 4000};
  localparam int unsigned SPIN_CYC [8] = '{
    SPIN_MS[0] * CYC_PER_MS, SPIN_MS[1] * CYC_PER_MS, SPIN_MS[2] * CYC_PER_MS, SPIN_MS[3] * CYC_PER_MS,
    SPIN_MS[4] * CYC_PER_MS, SPIN_MS[5] * CYC_PER_MS, SPIN_MS[6] * CYC_PER_MS, SPIN_MS[7] * CYC_PER_MS};

  // drive rate table, hundredths of a hertz, index = rate code
  localparam int unsigned RATE_CHZ [8] = '{1100, 1470, 2210, 2940, 3530, 4410, 5880, 8820};
  localparam int unsigned RATE_DIV [8] = '{
    STEP_HZ_X100 / RATE_CHZ[0], STEP_HZ_X100 / RATE_CHZ[1], STEP_HZ_X100 / RATE_CHZ[2],
    STEP_HZ_X100 / RATE_CHZ[3], STEP_HZ_X100 / RATE_CHZ[4], STEP_HZ_X100 / RATE_CHZ[5],
    STEP_HZ_X100 / RATE_CHZ[6], STEP_HZ_X100 / RATE_CHZ[7]};

  //////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_DUTY_1 = 8'h30;
  localparam logic [7:0] OFS_DUTY_2 = 8'h31;
  localparam logic [7:0] OFS_DUTY_3 = 8'h32;
  localparam logic [7:0] OFS_GCFG_1 = 8'h40;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h42;
  localparam logic [7:0] OFS_CHCFG_1 = 8'h5C;
  localparam logic [7:0] OFS_CHCFG_3 = 8'h5E;
  localparam logic [7:0] OFS_RATE_1 = 8'h5F;
  localparam logic [7:0] OFS_RATE_3 = 8'h61;
  localparam logic [7:0] OFS_XOR_TEST = 8'h6F;

  // field positions
  localparam int unsigned FIXED_SPINUP_BIT = 5;
  localparam int unsigned POLARITY_BIT = 4;
  localparam int unsigned BEHAV_LSB = 5;
  localparam int unsigned XOR_ENABLE_BIT = 0;
  localparam int unsigned FAULT_LSB = 2;

  // codes and reset values
  localparam logic [2:0] BEHAV_MANUAL = 3'h7;
  localparam logic [2:0] SPIN_NONE = 3'h0;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic [7:0] GCFG_RST = 8'h01;
  localparam logic [7:0] CHCFG_RST = 8'h02;
  localparam logic [2:0] RATE_RST = 3'h4;
  localparam logic [1:0] PULSES_DONE = 2'h2;

  typedef enum logic [1:0] {SPIN_OFF, SPIN_UP, SPIN_RUN} spin_state_e;

endpackage

// ---- hw/pwm_wave_gen.sv ----
/*
  One channel waveform: a prescaled 8-bit period counter compared to the duty.
  Assumes duty and divider come from flops on the same clock.
*/
`timescale 1ns/10ps

module pwm_wave_gen (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [pwm_fan_pkg::DIV_W-1:0] div_i,
  input wire logic [7:0] duty_i,
  input wire logic invert_i,
  output logic pwm_o
);

  typedef struct packed {
    logic [pwm_fan_pkg::DIV_W-1:0] pre;
    logic [7:0] cnt;
    logic out;
  } wave_s;

  wave_s q_r, q_nxt;
  logic high;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    q_nxt = q_r;
    // full code must stay high all period, so it bypasses the compare
    high = (duty_i == pwm_fan_pkg::DUTY_FULL) || (q_r.cnt < duty_i);
    if (q_r.pre >= div_i - 1'b1) begin
      q_nxt.pre = '0;
      q_nxt.cnt = q_r.cnt + 8'h01;
    end else begin
      q_nxt.pre = q_r.pre + 1'b1;
    end
    q_nxt.out = high ^ invert_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pwm_o = q_r.out;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_full_steady;
    (duty_i == pwm_fan_pkg::DUTY_FULL) && $stable(invert_i);
  endsequence

  a_full_level_polarity: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_full_steady ##1 s_full_steady |-> pwm_o == !invert_i)
    else $error("full duty level does not follow polarity");

  a_zero_duty_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (duty_i == pwm_fan_pkg::DUTY_ZERO) ##1 (duty_i == pwm_fan_pkg::DUTY_ZERO) && $stable(invert_i)
    |-> pwm_o == invert_i)
    else $error("zero duty drives active level");

endmodule // pwm_wave_gen

// ---- tb/fan_tach_model.sv ----
/*
  Behavioural cooling fan: two tach pulses per turn while it spins.
  Assumes the bench decides when the rotor turns; a stalled fan holds tach low.
*/
`timescale 1ns/10ps

module fan_tach_model #(
  parameter int unsigned PULSE_GAP = 20
) (
  input wire logic mclk_i,
  input wire logic spin_i,
  output logic tach_o
);
  int unsigned phase_r = 0;
  logic tach_r = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // a stalled rotor never toggles, so spin-up can only end by timeout
  always @(posedge mclk_i) begin
    if (!spin_i) begin
      phase_r <= 0;
      tach_r <= 1'b0;
    end else begin
      phase_r <= (phase_r == PULSE_GAP - 1) ? 0 : phase_r + 1;
      tach_r <= (phase_r < PULSE_GAP / 2);
    end
  end

  assign tach_o = tach_r;
endmodule // fan_tach_model

// ---- tb/test_pwm_fan_drive_control.sv ----
/*
  Self-checking bench for the three-channel fan drive block.
  Assumes shortened spin-up and rate tables; one fan model per channel.
*/
`timescale 1ns/10ps

module test_pwm_fan_drive_control;
  localparam int unsigned DIV [8] = '{8, 7, 6, 5, 4, 3, 2, 1};
  logic mclk_i;
  logic rstn_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic [2:0][7:0] auto_duty_i;
  wire [2:0] tach_i;
  logic [2:0] xor_chain_pins_i;
  logic [2:0] pwm_o;
  logic [2:0] fan_fault_o;
  logic [2:0] spin;
  logic xor_chain_enable_o;
  logic xor_chain_result_o;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  pwm_fan_drive_control #(
    .SPIN_CYCLES('{0, 100, 250, 400, 667, 1000, 2000, 4000}),
    .RATE_DIVIDERS(DIV)
  ) dut (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .auto_duty_i(auto_duty_i),
    .tach_i(tach_i),
    .xor_chain_pins_i(xor_chain_pins_i),
    .pwm_o(pwm_o),
    .fan_fault_o(fan_fault_o),
    .xor_chain_enable_o(xor_chain_enable_o),
    .xor_chain_result_o(xor_chain_result_o)
  );

  for (genvar i = 0; i < 3; i++) begin : g_fan
    fan_tach_model #(.PULSE_GAP(20)) fan (.mclk_i(mclk_i), .spin_i(spin[i]), .tach_o(tach_i[i]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bits(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: flags %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("ERROR %0t: high cycles %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data lands on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    cmp_byte(reg_rdata_o, exp);
  endtask

  // counts over whole periods only, so the phase of the counter does not matter
  task automatic meas_high(input int n, input int exp);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      if (pwm_o[0] === 1'b1) hi++;
    end
    cmp_count(hi, exp);
  endtask

  task automatic restart(input logic [2:0] m);
    @(posedge mclk_i);
    for (int c = 0; c < 3; c++) begin
      if (m[c]) auto_duty_i[c] <= 8'h00;
    end
    idle(4);
    for (int c = 0; c < 3; c++) begin
      if (m[c]) auto_duty_i[c] <= 8'h40;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // whole run is about 21k cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      $display("ERROR %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  initial begin
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    auto_duty_i = {3{8'h40}};
    xor_chain_pins_i = 3'h0;
    spin = 3'h0;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(8'h30, 8'hFF);
    rd(8'h31, 8'hFF);
    rd(8'h32, 8'hFF);
    rd(8'h5C, 8'h02);
    rd(8'h5E, 8'h02);
    rd(8'h5F, 8'h04);
    rd(8'h61, 8'h04);
    rd(8'h6F, 8'h00);
    rd(8'h3D, 8'h00);
    $display("test reset_values done");
    idle(200);
    #1;
    cmp_bits(fan_fault_o, 3'b000);
    idle(60);
    #1;
    cmp_bits(fan_fault_o, 3'b111);
    rd(8'h42, 8'h1C);
    rd(8'h42, 8'h00);
    rd(8'h30, 8'h40);
    @(posedge mclk_i);
    auto_duty_i[0] <= 8'h55;
    idle(3);
    rd(8'h30, 8'h55);
    $display("test start_timeout done");
    wr(8'h5D, 8'h07);
    spin <= 3'b011;
    restart(3'b011);
    idle(10);
    rd(8'h31, 8'hFF);
    rd(8'h30, 8'hFF);
    idle(60);
    rd(8'h31, 8'h40);
    rd(8'h30, 8'h40);
    rd(8'h42, 8'h00);
    $display("test tach_spinup done");
    wr(8'h40, 8'h21);
    rd(8'h40, 8'h21);
    wr(8'h5E, 8'h01);
    spin <= 3'b111;
    restart(3'b101);
    idle(60);
    rd(8'h32, 8'hFF);
    rd(8'h30, 8'hFF);
    idle(60);
    rd(8'h32, 8'h40);
    rd(8'h42, 8'h00);
    idle(150);
    rd(8'h30, 8'h40);
    $display("test fixed_spinup done");
    wr(8'h30, 8'h99);
    rd(8'h30, 8'h40);
    wr(8'h5C, 8'hE2);
    rd(8'h5C, 8'hE2);
    wr(8'h30, 8'h80);
    rd(8'h30, 8'h80);
    wr(8'h5F, 8'hFF);
    rd(8'h5F, 8'h07);
    for (int r = 0; r < 8; r++) begin
      wr(8'h5F, 8'(r));
      idle(256 * DIV[r] + 4);
      meas_high(256 * DIV[r], 128 * DIV[r]);
    end
    $display("test manual_rate done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h5C, (k < 2) ? 8'hE2 : 8'hF2);
      wr(8'h30, k[0] ? 8'h00 : 8'hFF);
      idle(260);
      meas_high(256, (k == 1 || k == 2) ? 0 : 256);
    end
    $display("test polarity done");
    wr(8'h6F, 8'hFF);
    rd(8'h6F, 8'h01);
    @(posedge mclk_i);
    xor_chain_pins_i <= 3'b011;
    idle(6);
    #1;
    cmp_bits({xor_chain_enable_o, xor_chain_result_o, 1'b0}, 3'b100);
    @(posedge mclk_i);
    xor_chain_pins_i <= 3'b111;
    idle(6);
    #1;
    cmp_bits({xor_chain_enable_o, xor_chain_result_o, 1'b0}, 3'b110);
    wr(8'h6F, 8'h00);
    idle(4);
    #1;
    cmp_bits({xor_chain_enable_o, xor_chain_result_o, 1'b0}, 3'b000);
    $display("test xor_chain done");
    stop_test();
  end
endmodule // test_pwm_fan_drive_control
